// *** shared/evt_timer_pkg.sv ***
// Package with register map, field positions, reset values and codes of the cascaded event timer.
package evt_timer_pkg;
  // ----------------------------------------------------------------
  // Register word addresses on the slave port
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE_CTL = 4'h0;
  localparam logic [3:0] ADDR_SRC_SEL = 4'h1;
  localparam logic [3:0] ADDR_OUT_CTL = 4'h2;
  localparam logic [3:0] ADDR_LOW_MATCH = 4'h3;
  localparam logic [3:0] ADDR_HIGH_MATCH = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RUN_BIT = 0;
  localparam int CASCADE_BIT = 2;
  localparam int WAVE_EN_BIT = 4;
  localparam int LOW_WAVE_EN_BIT = 0;
  localparam int EDGE_FALL_BIT = 4;
  localparam int IRQ_LOW_BIT = 0;
  localparam int IRQ_JOINT_BIT = 1;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CTL_RST = 8'h00;
  localparam logic [7:0] SRC_SEL_RST = 8'h00;
  localparam logic [7:0] OUT_CTL_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h3;
  // ----------------------------------------------------------------
  // Source select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_EXT_A = 4'h0;
  localparam logic [3:0] SRC_EXT_B = 4'h1;
  localparam logic [3:0] SRC_DIV_MIN = 4'h5;
  localparam logic [3:0] SRC_DIV_MAX_CODE = 4'hf;
  localparam int DIV_MAX_LOG2 = 12;
  localparam int DIV_BASE_SHIFT = 4;
  localparam int WAIT_CYCLES = 1;
  // Main clock period in ns and the prescaler tap nominal figures.
  localparam int REF_CLK_NS = 100;
  localparam int MIN_STEP_NS = 2 * REF_CLK_NS;
endpackage

// *** shared/count_if.sv ***
// Interface carrying the count enable and the event edge pulse between the timer's modules.
`timescale 1ns/1ns
`default_nettype none
interface count_if;
  logic tick;
  logic ext_edge;
  modport src (output tick, output ext_edge);
  modport sink (input tick, input ext_edge);
endinterface
`default_nettype wire

// *** hdl/tick_source.sv ***
// Prescaler and event edge detector that produce the low counter's count enable.
`timescale 1ns/1ns
`default_nettype none
module tick_source
  import evt_timer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [3:0] src_sel,
  input wire logic edge_fall,
  // Event pin
  input wire logic event_pulse_input,
  // Tick out
  count_if.src cnt
);
  logic [DIV_MAX_LOG2-1:0] pre_q;
  logic pin_q;
  logic rise_w;
  logic fall_w;
  logic ext_sel_w;
  logic [3:0] shift_w;
  logic div_tick_w;
  logic [DIV_MAX_LOG2-1:0] mask_w;

  // ----------------------------------------------------------------
  // Divider taps
  // ----------------------------------------------------------------
  // Codes 5..14 map to 2^1..2^10; code 15 maps to 2^12.
  assign shift_w = (src_sel == SRC_DIV_MAX_CODE) ? 4'(DIV_MAX_LOG2) : src_sel - 4'(DIV_BASE_SHIFT);
  assign mask_w = DIV_MAX_LOG2'((1 << shift_w) - 1);
  assign div_tick_w = (src_sel >= SRC_DIV_MIN) && ((pre_q & mask_w) == mask_w);
  assign ext_sel_w = (src_sel == SRC_EXT_A) || (src_sel == SRC_EXT_B);
  assign rise_w = event_pulse_input && !pin_q;
  assign fall_w = !event_pulse_input && pin_q;
  assign cnt.ext_edge = ext_sel_w && (edge_fall ? fall_w : rise_w);
  assign cnt.tick = run && (ext_sel_w ? cnt.ext_edge : div_tick_w);

  // Prescaler free-runs; a start therefore lands anywhere in a period.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      pin_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 1'b1;
      pin_q <= event_pulse_input;
    end
  end
endmodule
`default_nettype wire

// *** hdl/cascade_counter.sv ***
// Cascaded low and high 8-bit counters with joint and low match detection.
`timescale 1ns/1ns
`default_nettype none
module cascade_counter
  import evt_timer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic cascade,
  input wire logic [7:0] low_match_value,
  input wire logic [7:0] high_match_value,
  // Tick in
  count_if.sink cnt,
  // Results
  output logic [15:0] count,
  output logic low_hit,
  output logic joint_hit
);
  logic [7:0] low_count_reg_q;
  logic [7:0] high_count_reg_q;
  logic low_eq_w;
  logic high_eq_w;
  logic low_ovf_w;

  assign low_eq_w = low_count_reg_q == low_match_value;
  assign high_eq_w = high_count_reg_q == high_match_value;
  assign low_ovf_w = cnt.tick && (low_count_reg_q == 8'hff);
  // Match is judged when a count pulse arrives, so a zero compare fires on one pulse.
  assign joint_hit = cnt.tick && cascade && low_eq_w && high_eq_w;
  assign low_hit = cnt.tick && low_eq_w;
  assign count = {high_count_reg_q, low_count_reg_q};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_count_reg_q <= 8'h00;
      high_count_reg_q <= 8'h00;
    end else if (!run) begin
      low_count_reg_q <= low_count_reg_q;
    end else if (joint_hit) begin
      low_count_reg_q <= 8'h00;
      high_count_reg_q <= 8'h00;
    end else if (cnt.tick) begin
      // An equality only clears jointly; a lowered compare is passed by and wraps.
      low_count_reg_q <= low_count_reg_q + 8'h01;
      if (cascade && low_ovf_w) begin
        high_count_reg_q <= high_count_reg_q + 8'h01;
      end
    end
  end

  a_high_follows_ovf: assert property (@(posedge ref_clk) disable iff (rst)
    (run && cascade && low_ovf_w && !joint_hit) |=> (high_count_reg_q == $past(high_count_reg_q) + 8'h01))
    else $error("high counter missed low overflow");
  a_joint_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (run && joint_hit) |=> (count == 16'h0000))
    else $error("joint match did not clear counters");
  a_stop_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !run |=> $stable(count))
    else $error("count moved while stopped");
  a_low_wraps: assert property (@(posedge ref_clk) disable iff (rst)
    (run && cnt.tick && !joint_hit && low_count_reg_q == 8'hff) |=> (low_count_reg_q == 8'h00))
    else $error("low counter did not wrap");
  a_no_high_plain: assert property (@(posedge ref_clk) disable iff (rst)
    (!cascade && !joint_hit) |=> $stable(high_count_reg_q))
    else $error("high counter moved outside cascade");
  a_edge_counts: assert property (@(posedge ref_clk) disable iff (rst)
    (run && cnt.ext_edge && (low_count_reg_q != low_match_value))
    |=> (low_count_reg_q == $past(low_count_reg_q) + 8'h01))
    else $error("event edge did not advance low counter");
endmodule
`default_nettype wire

// *** hdl/evt_timer.sv ***
// Top of the cascaded 16-bit event timer with its Avalon-MM register slave.
// Behaviour
// - Setting cascade bit 2 of mode control joins both counters into 16 bits.
// - In cascade, counting runs only while run bit 0 of mode control is one.
// - Source bits 0..3 pick event edges or main clock divided 2 to 2^12.
// - With the event source chosen, each valid pin edge adds one to low count.
// - Software chooses rising or falling as the valid event edge.
// - In cascade, each low counter overflow advances the high counter by one.
// - In cascade, joint equality of both counters clears both and raises the joint interrupt.
// - Low equality alone raises the low interrupt and, with low wave enable bit 0 of output control set, toggles the low wave output.
// - With wave enable bit 4 set, the high wave output toggles on joint match.
// - First match after start may be one count clock early or late.
// - A zero compare value is legal; one input pulse matches, and in cascade with both compares zero also clears.
// - A compare lowered below the count is reached only after wrap to zero.
// - The 16-bit count is read in one access capturing both bytes together.
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module evt_timer
  import evt_timer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Event pin and wave outputs
  input wire logic event_pulse_input,
  output logic low_wave_output,
  output logic high_wave_output,
  // Interrupt
  output logic irq
);
  logic [7:0] low_timer_mode_ctl_q;
  logic [7:0] count_source_select_q;
  logic [7:0] output_control_q;
  logic [7:0] low_match_value_q;
  logic [7:0] high_match_value_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic ack_q;
  logic [31:0] rdata_d;
  logic hit_addr_w;
  logic wr_w;
  logic rd_w;
  logic [3:0] word_w;
  logic low_hit_w;
  logic joint_hit_w;
  logic [15:0] count_w;
  logic run_w;
  logic cascade_w;
  logic [1:0] irq_set_w;
  logic [1:0] irq_clr_w;

  count_if cnt_bus();

  // ----------------------------------------------------------------
  // Counting core
  // ----------------------------------------------------------------
  assign run_w = low_timer_mode_ctl_q[RUN_BIT];
  assign cascade_w = low_timer_mode_ctl_q[CASCADE_BIT];

  tick_source u_src (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(run_w),
    .src_sel(count_source_select_q[3:0]),
    .edge_fall(count_source_select_q[EDGE_FALL_BIT]),
    .event_pulse_input(event_pulse_input),
    .cnt(cnt_bus.src)
  );

  cascade_counter u_cnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(run_w),
    .cascade(cascade_w),
    .low_match_value(low_match_value_q),
    .high_match_value(high_match_value_q),
    .cnt(cnt_bus.sink),
    .count(count_w),
    .low_hit(low_hit_w),
    .joint_hit(joint_hit_w)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // The slave is word addressed, so eight registers fit the four address bits.
  // Every access waits one cycle so read data come from a flop at the accepting edge.
  assign word_w = address;
  assign hit_addr_w = (word_w <= ADDR_IRQ_MASK);
  assign waitrequest = (read || write) && !ack_q;
  assign wr_w = write && ack_q && hit_addr_w && byteenable[0];
  assign rd_w = read && !ack_q;
  assign irq_set_w = {joint_hit_w, low_hit_w};
  assign irq_clr_w = (wr_w && word_w == ADDR_IRQ_STATUS) ? writedata[1:0] : 2'b00;
  assign irq = |(irq_status_q & ~irq_mask_q);

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (word_w)
      ADDR_MODE_CTL: rdata_d[7:0] = low_timer_mode_ctl_q;
      ADDR_SRC_SEL: rdata_d[7:0] = count_source_select_q;
      ADDR_OUT_CTL: rdata_d[7:0] = output_control_q;
      ADDR_LOW_MATCH: rdata_d[7:0] = low_match_value_q;
      ADDR_HIGH_MATCH: rdata_d[7:0] = high_match_value_q;
      ADDR_COUNT: rdata_d[15:0] = count_w;
      ADDR_IRQ_STATUS: rdata_d[1:0] = irq_status_q;
      ADDR_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Handshake and read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      readdata <= 32'h0000_0000;
      response <= 2'b00;
    end else begin
      ack_q <= (read || write) && !ack_q;
      if (rd_w) begin
        readdata <= hit_addr_w ? rdata_d : 32'h0000_0000;
      end
      if ((read || write) && !ack_q) begin
        response <= hit_addr_w ? 2'b00 : 2'b10;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Compare writes are taken at any time; stopping first is left to software.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_timer_mode_ctl_q <= MODE_CTL_RST;
      count_source_select_q <= SRC_SEL_RST;
      output_control_q <= OUT_CTL_RST;
      low_match_value_q <= MATCH_RST;
      high_match_value_q <= MATCH_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_w) begin
      unique case (word_w)
        ADDR_MODE_CTL: low_timer_mode_ctl_q <= writedata[7:0];
        ADDR_SRC_SEL: count_source_select_q <= writedata[7:0];
        ADDR_OUT_CTL: output_control_q <= writedata[7:0];
        ADDR_LOW_MATCH: low_match_value_q <= writedata[7:0];
        ADDR_HIGH_MATCH: high_match_value_q <= writedata[7:0];
        ADDR_IRQ_MASK: irq_mask_q <= writedata[1:0];
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and wave outputs
  // ----------------------------------------------------------------
  // A hit in the clearing cycle survives because set is ORed after clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= 2'b00;
      low_wave_output <= 1'b0;
      high_wave_output <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr_w) | irq_set_w;
      if (low_hit_w && output_control_q[LOW_WAVE_EN_BIT]) begin
        low_wave_output <= !low_wave_output;
      end
      if (joint_hit_w && output_control_q[WAVE_EN_BIT]) begin
        high_wave_output <= !high_wave_output;
      end
    end
  end

  a_joint_sets_irq: assert property (@(posedge ref_clk) disable iff (rst)
    joint_hit_w |=> irq_status_q[IRQ_JOINT_BIT])
    else $error("joint match lost its status bit");
  a_low_sets_irq: assert property (@(posedge ref_clk) disable iff (rst)
    low_hit_w |=> irq_status_q[IRQ_LOW_BIT])
    else $error("low match lost its status bit");
  a_wave_toggles: assert property (@(posedge ref_clk) disable iff (rst)
    (joint_hit_w && output_control_q[WAVE_EN_BIT]) |=> (high_wave_output != $past(high_wave_output)))
    else $error("high wave output did not toggle");
  a_wave_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !joint_hit_w |=> $stable(high_wave_output))
    else $error("high wave output moved without joint match");
  a_count_read: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_w && word_w == ADDR_COUNT && hit_addr_w) |=> (readdata[15:0] == $past(count_w)))
    else $error("count read not captured whole");
endmodule
`default_nettype wire

// *** tb/event_src.sv ***
// Behavioural model of the external event pulse source driving the timer's event pin.
`timescale 1ns/1ns
`default_nettype none
module event_src (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control from the bench
  input wire logic fire,
  input wire logic [7:0] n_pulses,
  input wire logic flip,
  // Event pin and status
  output logic pin,
  output logic busy
);
  // ----------------------------------------------------------------
  // Pulse train
  // ----------------------------------------------------------------
  // Each level lasts four cycles so that a sampling edge detector sees every edge.
  logic [7:0] left_q;
  logic [1:0] ph_q;
  logic hi_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      left_q <= 8'h00;
      ph_q <= 2'h0;
      hi_q <= 1'b0;
    end else if (fire) begin
      left_q <= n_pulses;
      ph_q <= 2'h0;
      hi_q <= 1'b0;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        hi_q <= ~hi_q;
        if (hi_q) begin
          left_q <= left_q - 8'h01;
        end
      end
    end
  end
  // Flip lets the bench make single rising or falling steps on an idle pin.
  assign pin = hi_q ^ flip;
  assign busy = (left_q != 8'h00);
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench of the cascaded event timer through its Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import evt_timer_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  logic fire = 1'b0;
  logic [7:0] n_pulses = 8'h00;
  logic flip = 1'b0;
  wire logic [31:0] readdata;
  wire logic waitrequest;
  wire logic [1:0] response;
  wire logic event_pulse_input;
  wire logic low_wave_output;
  wire logic high_wave_output;
  wire logic irq;
  wire logic busy;
  int fails = 0;
  int checked = 0;
  logic [31:0] q;
  logic [1:0] r;
  logic [31:0] c0;
  int k;
  int w;
  int div;
  always #50 ref_clk = ~ref_clk;
  evt_timer evt_timer_i (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .event_pulse_input(event_pulse_input),
    .low_wave_output(low_wave_output), .high_wave_output(high_wave_output), .irq(irq));
  event_src event_src_i (.ref_clk(ref_clk), .rst(rst), .fire(fire), .n_pulses(n_pulses),
    .flip(flip), .pin(event_pulse_input), .busy(busy));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // The request stands until waitrequest is sampled low at a rising edge; the watchdog ends a hang.
  task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    read <= ~is_wr;
    write <= is_wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    byteenable <= 4'hf;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic do_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task automatic pulses(input logic [7:0] n);
    @(posedge ref_clk);
    fire <= 1'b1;
    n_pulses <= n;
    @(posedge ref_clk);
    fire <= 1'b0;
    @(negedge ref_clk);
    while (busy !== 1'b0) begin
      @(negedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic step(input logic v);
    @(posedge ref_clk);
    flip <= v;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (k = 0; k < 8; k++) begin
      rd(k[3:0]);
      chk(q, (k == 7) ? 32'h0000_0003 : 32'h0000_0000);
    end
    rd(4'h9);
    chk(q, 32'h0000_0000);
    chk(32'(r), 32'h0000_0002);
    $display("test reset values done");
    wr(ADDR_MODE_CTL, 8'h05);
    pulses(8'h01);
    rd(ADDR_IRQ_STATUS);
    chk(q, 32'h0000_0003);
    rd(ADDR_COUNT);
    chk(q, 32'h0000_0000);
    $display("test zero compare done");
    wr(ADDR_MODE_CTL, 8'h04);
    wr(ADDR_HIGH_MATCH, 8'hff);
    wr(ADDR_LOW_MATCH, 8'hff);
    wr(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_MODE_CTL, 8'h05);
    pulses(8'h05);
    rd(ADDR_COUNT);
    chk(q, 32'h0000_0005);
    step(1'b1);
    rd(ADDR_COUNT);
    chk(q, 32'h0000_0006);
    step(1'b0);
    rd(ADDR_COUNT);
    chk(q, 32'h0000_0006);
    wr(ADDR_SRC_SEL, 8'h10);
    step(1'b1);
    rd(ADDR_COUNT);
    chk(q, 32'h0000_0006);
    step(1'b0);
    rd(ADDR_COUNT);
    chk(q, 32'h0000_0007);
    wr(ADDR_SRC_SEL, 8'h01);
    pulses(8'h01);
    rd(ADDR_COUNT);
    chk(q, 32'h0000_0008);
    $display("test event edges done");
    // Counter is not cleared between codes, so each rate is judged by difference.
    for (k = 2; k < 16; k++) begin
      wr(ADDR_MODE_CTL, 8'h04);
      wr(ADDR_SRC_SEL, k[7:0]);
      rd(ADDR_COUNT);
      c0 = q;
      div = (k < 5) ? 0 : ((k == 15) ? 4096 : (1 << (k - 4)));
      wr(ADDR_MODE_CTL, 8'h05);
      repeat ((k < 5) ? 64 : 4 * div) @(posedge ref_clk);
      wr(ADDR_MODE_CTL, 8'h04);
      rd(ADDR_COUNT);
      if (k < 5) begin
        chk(q - c0, 32'h0000_0000);
      end else begin
        chk(32'(((q - c0) >= 3) && ((q - c0) <= 6)), 32'h0000_0001);
      end
    end
    $display("test source rates done");
    do_reset;
    wr(ADDR_LOW_MATCH, 8'h02);
    wr(ADDR_HIGH_MATCH, 8'h01);
    wr(ADDR_OUT_CTL, 8'h11);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_SRC_SEL, 8'h05);
    wr(ADDR_MODE_CTL, 8'h05);
    repeat (100) @(posedge ref_clk);
    rd(ADDR_IRQ_STATUS);
    chk(q, 32'h0000_0001);
    chk(32'(low_wave_output), 32'h0000_0001);
    chk(32'(high_wave_output), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    w = 0;
    @(negedge ref_clk);
    while (irq !== 1'b1 && w < 1000) begin
      @(negedge ref_clk);
      w++;
    end
    chk(32'(w >= 405 && w <= 425), 32'h0000_0001);
    chk(32'(high_wave_output), 32'h0000_0001);
    wr(ADDR_MODE_CTL, 8'h04);
    rd(ADDR_IRQ_STATUS);
    chk(q, 32'h0000_0003);
    rd(ADDR_COUNT);
    c0 = q;
    chk(32'(q[15:8]), 32'h0000_0000);
    repeat (50) @(posedge ref_clk);
    rd(ADDR_COUNT);
    chk(q, c0);
    wr(ADDR_IRQ_STATUS, 8'h02);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 8'h00);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0001);
    wr(ADDR_IRQ_STATUS, 8'h01);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    $display("test cascade match done");
    do_reset;
    wr(ADDR_LOW_MATCH, 8'hff);
    wr(ADDR_SRC_SEL, 8'h05);
    wr(ADDR_MODE_CTL, 8'h01);
    repeat (128) @(posedge ref_clk);
    wr(ADDR_MODE_CTL, 8'h00);
    rd(ADDR_COUNT);
    c0 = q;
    wr(ADDR_LOW_MATCH, c0[7:0] - 8'h20);
    wr(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_MODE_CTL, 8'h01);
    repeat (40) @(posedge ref_clk);
    rd(ADDR_IRQ_STATUS);
    chk(q, 32'h0000_0000);
    repeat (700) @(posedge ref_clk);
    rd(ADDR_IRQ_STATUS);
    chk(q, 32'h0000_0001);
    rd(ADDR_COUNT);
    chk(32'(q[15:8]), 32'h0000_0000);
    $display("test wrap and single mode done");
    close_out;
  end
  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // The tests need about 30000 cycles; 60000 cycles leave a wide margin.
  initial begin
    #6_000_000;
    fails++;
    close_out;
  end
endmodule
`default_nettype wire
